// >>> hdl/pmti_core.sv
// bus master/target interface: config target, burst initiator, parity, register slave
// Operation
// - 256-byte config space honouring byte enables
// - idsel selects config cycle, devsel_l claims
// - req_l released as frame_l first asserts
// - frame_l starts only with gnt_l asserted
// - grant loss at frame start is ignored
// - withdrawn grant delays frame_l until regranted
// - address and command, then byte enables 0000
// - read keeps irdy_l, captures on irdy/trdy
// - write data phase completes on irdy/trdy
// - frame_l high marks last phase, then irdy_l
// - timer expiry without grant: two more phases
// - no devsel in five: master abort flags
// - stop without devsel: target abort flags
// - disconnect: release, later repeat last transfer
// - retry: release, later repeat last two transfers
// - target burst: stop_l held until frame_l high
// - parity checked and generated on ad, cbe
// - parity driven one clock after ad
// - driven ad and cbe lines always defined
// - master parity error sets report flags
// - serr_l pulse on address, perr_l on data
// - target burst: first phase done, retry second
// - idle bus with grant: park the bus
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`include "pmti_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pmti_core #(
	parameter logic [31:0] ID_WORD = 32'h5A5A_0001 // arbitrary identity word
) (
	input wire logic sys_clk, // 40 MHz clock
	input wire logic rst, // async reset, high
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write phase
	input wire logic [2:0] hsize, // word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	output logic [31:0] hrdata, // read data
	input wire pmti_pkg::pmti_pci_in_t pci_i, // pin levels
	output var pmti_pkg::pmti_pci_out_t pci_o // pin drive and enables
);
	pmti_pkg::pmti_state_t q;
	pmti_pkg::pmti_state_t n;

	function automatic logic par_fn(input logic [31:0] ad, input logic [3:0] cbe);
		par_fn = ^{ad, cbe};
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be_l);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (!be_l[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		be_merge = r;
	endfunction

	function automatic logic [4:0] sub_sat(input logic [4:0] a, input logic [4:0] b);
		sub_sat = (a >= b) ? a - b : 5'h00;
	endfunction

	function automatic logic [31:0] config_command_status_reg_word(input pmti_pkg::pmti_state_t s);
		logic [31:0] w;
		w = {16'h0000, s.cmdreg};
		w[`PMTI_CONFIG_COMMAND_STATUS_REG_DPR] = s.dpr;
		w[`PMTI_CONFIG_COMMAND_STATUS_REG_RTA] = s.rta;
		w[`PMTI_CONFIG_COMMAND_STATUS_REG_RMA] = s.rma;
		config_command_status_reg_word = w;
	endfunction

	function automatic logic [31:0] cfg_read(input pmti_pkg::pmti_state_t s, input logic [5:0] i);
		if (i == `PMTI_CFG_ID_IDX) begin
			cfg_read = ID_WORD;
		end else if (i == `PMTI_CFG_CSR_IDX) begin
			cfg_read = config_command_status_reg_word(s);
		end else begin
			cfg_read = s.cfg[i];
		end
	endfunction

	function automatic logic [31:0] reg_read(input pmti_pkg::pmti_state_t s, input logic [7:0] ofs);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (ofs[7:6] == `PMTI_BUF_SEL) begin
			w = s.dbuf[ofs[5:2]];
		end else if (ofs == `PMTI_OFS_MADDR) begin
			w = s.maddr;
		end else if (ofs == `PMTI_OFS_MCTRL) begin
			w[`PMTI_CTRL_GO] = s.busy;
			w[`PMTI_CTRL_WR] = s.mwr;
			w[`PMTI_CTRL_LEN_LSB +: 5] = s.mlen;
			w[`PMTI_CTRL_LAT_LSB +: 8] = s.lat;
		end else if (ofs == `PMTI_OFS_CONFIG_COMMAND_STATUS_REG) begin
			w = config_command_status_reg_word(s);
		end else if (ofs == `PMTI_OFS_CSTAT) begin
			w[`PMTI_CSTAT_BUSY] = s.busy;
			w[`PMTI_CSTAT_FBE_M] = s.fbe_m;
			w[`PMTI_CSTAT_FBE_T] = s.fbe_t;
		end
		reg_read = w;
	endfunction

	function automatic logic is_iomem(input logic [3:0] c);
		is_iomem = (c == `PMTI_CMD_IORD) || (c == `PMTI_CMD_IOWR) || (c == `PMTI_CMD_MRD)
			|| (c == `PMTI_CMD_MWR) || (c == `PMTI_CMD_MRM) || (c == `PMTI_CMD_MRL) || (c == `PMTI_CMD_MWI);
	endfunction

	logic gnt;
	logic bus_idle;
	logic xfer;
	logic start_addr;
	logic cfg_hit;
	logic mem_hit;
	logic [4:0] nidx;
	logic [31:0] w;

	always_comb begin
		gnt = 1'b0;
		bus_idle = 1'b0;
		xfer = 1'b0;
		start_addr = 1'b0;
		cfg_hit = 1'b0;
		mem_hit = 1'b0;
		nidx = 5'h00;
		w = 32'h0000_0000;
		n = q;
		n.s1 = pci_i;
		n.s2 = q.s1;
		n.s3 = q.s2;
		gnt = !q.s2.gnt_l;
		bus_idle = q.s2.frame_l && q.s2.irdy_l;
		// parity follows the driven word by one clock
		n.o.par = par_fn(q.o.ad, q.o.cbe_oe ? q.o.cbe_l : q.s2.cbe_l);
		n.o.par_oe = q.o.ad_oe;
		n.o.serr_l = 1'b1;
		n.o.serr_oe = 1'b0;
		n.o.perr_l = 1'b1;
		n.o.perr_oe = 1'b0;
		n.pexp = par_fn(q.s2.ad, q.s2.cbe_l);
		n.pchk = 1'b0;
		// register slave: zero wait, read data registered at the address phase
		n.hrdy = 1'b1;
		n.ahb_ap = hsel && htrans[1] && hready;
		n.ahb_wr = hwrite;
		n.ahb_ofs = haddr[7:0];
		if (hsel && htrans[1] && hready && !hwrite) begin
			n.hrdata = reg_read(q, haddr[7:0]);
		end
		if (q.ahb_ap && q.ahb_wr) begin
			if (q.ahb_ofs[7:6] == `PMTI_BUF_SEL) begin
				n.dbuf[q.ahb_ofs[5:2]] = hwdata;
			end else if (q.ahb_ofs == `PMTI_OFS_MADDR && !q.busy) begin
				n.maddr = hwdata;
			end else if (q.ahb_ofs == `PMTI_OFS_MCTRL && !q.busy) begin
				n.mwr = hwdata[`PMTI_CTRL_WR];
				n.mlen = hwdata[`PMTI_CTRL_LEN_LSB +: 5];
				n.lat = hwdata[`PMTI_CTRL_LAT_LSB +: 8];
				if (hwdata[`PMTI_CTRL_GO] && hwdata[`PMTI_CTRL_LEN_LSB +: 5] != 5'h00) begin
					n.busy = 1'b1;
					n.idx = 5'h00;
				end
			end else if (q.ahb_ofs == `PMTI_OFS_CONFIG_COMMAND_STATUS_REG) begin
				n.cmdreg = hwdata[15:0];
				n.dpr = q.dpr && !hwdata[`PMTI_CONFIG_COMMAND_STATUS_REG_DPR];
				n.rta = q.rta && !hwdata[`PMTI_CONFIG_COMMAND_STATUS_REG_RTA];
				n.rma = q.rma && !hwdata[`PMTI_CONFIG_COMMAND_STATUS_REG_RMA];
			end else if (q.ahb_ofs == `PMTI_OFS_CSTAT) begin
				n.fbe_m = q.fbe_m && !hwdata[`PMTI_CSTAT_FBE_M];
				n.fbe_t = q.fbe_t && !hwdata[`PMTI_CSTAT_FBE_T];
			end
		end
		// initiator
		n.latcnt = (q.latcnt == 8'hFF) ? q.latcnt : q.latcnt + 8'h01;
		unique case (q.m)
			pmti_pkg::M_IDLE: begin
				if (q.busy && q.t == pmti_pkg::T_IDLE) begin
					n.o.req_l = 1'b0;
					n.m = pmti_pkg::M_REQ;
				end else if (gnt && bus_idle && q.t == pmti_pkg::T_IDLE) begin
					n.o.ad = 32'h0000_0000;
					n.o.cbe_l = `PMTI_BE_ALL;
					n.o.ad_oe = 1'b1;
					n.o.cbe_oe = 1'b1;
					n.m = pmti_pkg::M_PARK;
				end
			end
			pmti_pkg::M_PARK: begin
				if (!gnt || !bus_idle) begin
					n.o.ad_oe = 1'b0;
					n.o.cbe_oe = 1'b0;
					n.m = pmti_pkg::M_IDLE;
				end else if (q.busy) begin
					start_addr = 1'b1;
				end
			end
			pmti_pkg::M_REQ: begin
				start_addr = gnt && bus_idle;
			end
			pmti_pkg::M_ADDR: begin
				// grant loss here does not stop the transaction
				n.o.irdy_l = 1'b0;
				n.o.cbe_l = `PMTI_BE_ALL;
				n.o.ad = q.mwr ? q.dbuf[q.idx[3:0]] : 32'h0000_0000;
				n.o.ad_oe = q.mwr;
				n.o.frame_l = (q.idx + 5'h01 >= q.tlim);
				n.m = pmti_pkg::M_DATA;
			end
			pmti_pkg::M_DATA: begin
				xfer = !q.s2.trdy_l && !q.o.irdy_l;
				if (!q.s2.devsel_l) begin
					n.devseen = 1'b1;
				end
				if (!gnt && q.latcnt >= q.lat && q.tlim > q.idx + `PMTI_TO_EXTRA) begin
					n.tlim = q.idx + `PMTI_TO_EXTRA;
				end
				if (!q.devseen && q.s2.devsel_l && q.dwait == `PMTI_DEVSEL_WAIT) begin
					n.o.frame_l = 1'b1;
					n.rma = 1'b1;
					n.fbe_m = 1'b1;
					n.busy = 1'b0;
					n.m = pmti_pkg::M_FIN;
				end else if (!q.s2.stop_l && q.s2.devsel_l) begin
					n.o.frame_l = 1'b1;
					n.o.irdy_l = 1'b1;
					n.rta = 1'b1;
					n.fbe_t = 1'b1;
					n.busy = 1'b0;
					n.m = pmti_pkg::M_END;
				end else if (!q.s2.stop_l) begin
					nidx = q.idx + {4'h0, xfer};
					if (xfer && !q.mwr) begin
						n.dbuf[q.idx[3:0]] = q.s2.ad;
					end
					n.idx = sub_sat(nidx, q.s2.trdy_l ? `PMTI_BACK_RETRY : `PMTI_BACK_DISC);
					n.o.frame_l = 1'b1;
					n.m = pmti_pkg::M_FIN;
				end else begin
					n.dwait = q.dwait + {2'h0, !n.devseen};
					if (xfer) begin
						nidx = q.idx + 5'h01;
						n.idx = nidx;
						if (!q.mwr) begin
							n.dbuf[q.idx[3:0]] = q.s2.ad;
							n.pchk = 1'b1;
							n.pdata = 1'b1;
							n.pmst = 1'b1;
						end
						if (q.o.frame_l) begin
							n.o.irdy_l = 1'b1;
							n.o.ad_oe = 1'b0;
							n.busy = (nidx < q.mlen);
							n.m = pmti_pkg::M_END;
						end else begin
							n.o.ad = q.mwr ? q.dbuf[nidx[3:0]] : 32'h0000_0000;
							n.o.frame_l = (nidx + 5'h01 >= n.tlim);
						end
					end else if (!q.o.frame_l) begin
						n.o.frame_l = (q.idx + 5'h01 >= n.tlim);
					end
				end
			end
			pmti_pkg::M_FIN: begin
				n.o.irdy_l = 1'b1;
				n.o.ad_oe = 1'b0;
				n.m = pmti_pkg::M_END;
			end
			pmti_pkg::M_END: begin
				n.o.frame_oe = 1'b0;
				n.o.irdy_oe = 1'b0;
				n.o.ad_oe = 1'b0;
				n.o.cbe_oe = 1'b0;
				n.m = pmti_pkg::M_IDLE;
			end
			default: begin
				n.m = pmti_pkg::M_IDLE;
			end
		endcase
		if (start_addr) begin
			n.o.req_l = 1'b1;
			n.o.frame_l = 1'b0;
			n.o.frame_oe = 1'b1;
			n.o.irdy_l = 1'b1;
			n.o.irdy_oe = 1'b1;
			n.o.ad = q.maddr + {25'h0, q.idx, 2'b00};
			n.o.ad_oe = 1'b1;
			n.o.cbe_l = q.mwr ? `PMTI_CMD_MWR : `PMTI_CMD_MRD;
			n.o.cbe_oe = 1'b1;
			n.tlim = q.mlen;
			n.dwait = 3'h1;
			n.devseen = 1'b0;
			n.latcnt = 8'h00;
			n.m = pmti_pkg::M_ADDR;
		end
		// target
		unique case (q.t)
			pmti_pkg::T_IDLE: begin
				if (!q.s2.frame_l && q.s3.frame_l && q.m == pmti_pkg::M_IDLE) begin
					cfg_hit = q.s2.idsel && q.s2.cbe_l[3:1] == `PMTI_CMD_CFG_HI;
					mem_hit = is_iomem(q.s2.cbe_l) && |q.cmdreg[1:0]
						&& q.s2.ad[31:8] == q.cfg[`PMTI_CFG_BAR_IDX][31:8];
					if (cfg_hit || mem_hit) begin
						n.pchk = 1'b1;
						n.pdata = 1'b0;
						n.tidx = q.s2.ad[7:2];
						n.tcmd = q.s2.cbe_l;
						n.tcfg = cfg_hit;
						n.o.devsel_l = 1'b0;
						n.o.devsel_oe = 1'b1;
						n.o.trdy_l = 1'b1;
						n.o.trdy_oe = 1'b1;
						n.o.stop_l = 1'b1;
						n.o.stop_oe = 1'b1;
						n.t = pmti_pkg::T_CLAIM;
					end
				end
			end
			pmti_pkg::T_CLAIM: begin
				if (!q.tcmd[0]) begin
					n.o.ad = q.tcfg ? cfg_read(q, q.tidx) : 32'h0000_0000;
					n.o.ad_oe = 1'b1;
				end
				n.o.trdy_l = 1'b0;
				n.t = pmti_pkg::T_DATA;
			end
			pmti_pkg::T_DATA: begin
				if (!q.s2.irdy_l) begin
					if (q.tcmd[0]) begin
						n.pchk = 1'b1;
						n.pdata = 1'b1;
						n.pmst = 1'b0;
						if (q.tcfg && q.tidx == `PMTI_CFG_CSR_IDX) begin
							w = be_merge({16'h0000, q.cmdreg}, q.s2.ad, q.s2.cbe_l);
							n.cmdreg = w[15:0];
							n.dpr = q.dpr && !(w[`PMTI_CONFIG_COMMAND_STATUS_REG_DPR] && !q.s2.cbe_l[3]);
							n.rta = q.rta && !(w[`PMTI_CONFIG_COMMAND_STATUS_REG_RTA] && !q.s2.cbe_l[3]);
							n.rma = q.rma && !(w[`PMTI_CONFIG_COMMAND_STATUS_REG_RMA] && !q.s2.cbe_l[3]);
						end else if (q.tcfg && q.tidx != `PMTI_CFG_ID_IDX) begin
							n.cfg[q.tidx] = be_merge(q.cfg[q.tidx], q.s2.ad, q.s2.cbe_l);
						end
					end
					n.o.trdy_l = 1'b1;
					if (!q.s2.frame_l) begin
						n.o.stop_l = 1'b0;
						n.t = pmti_pkg::T_STOP;
					end else begin
						n.o.devsel_l = 1'b1;
						n.o.ad_oe = 1'b0;
						n.t = pmti_pkg::T_TURN;
					end
				end
			end
			pmti_pkg::T_STOP: begin
				if (q.s2.frame_l) begin
					n.o.stop_l = 1'b1;
					n.o.devsel_l = 1'b1;
					n.o.ad_oe = 1'b0;
					n.t = pmti_pkg::T_TURN;
				end
			end
			pmti_pkg::T_TURN: begin
				n.o.devsel_oe = 1'b0;
				n.o.trdy_oe = 1'b0;
				n.o.stop_oe = 1'b0;
				n.o.ad_oe = 1'b0;
				n.t = pmti_pkg::T_IDLE;
			end
			default: begin
				n.t = pmti_pkg::T_IDLE;
			end
		endcase
		// parity check one clock after the checked word; flag sets come last so they win
		if (q.pchk && q.s2.par != q.pexp) begin
			if (!q.pdata) begin
				n.o.serr_l = 1'b0;
				n.o.serr_oe = 1'b1;
			end else begin
				n.o.perr_l = 1'b0;
				n.o.perr_oe = 1'b1;
				if (q.pmst) begin
					n.dpr = 1'b1;
					n.fbe_m = 1'b1;
				end
			end
		end
		if (q.m != pmti_pkg::M_IDLE && q.m != pmti_pkg::M_PARK && !q.s2.perr_l) begin
			n.dpr = 1'b1;
			n.fbe_m = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.s1 <= '1;
			q.s2 <= '1;
			q.s3 <= '1;
			q.o.req_l <= 1'b1;
			q.o.frame_l <= 1'b1;
			q.o.irdy_l <= 1'b1;
			q.o.trdy_l <= 1'b1;
			q.o.devsel_l <= 1'b1;
			q.o.stop_l <= 1'b1;
			q.o.cbe_l <= 4'hF;
			q.o.perr_l <= 1'b1;
			q.o.serr_l <= 1'b1;
			q.hrdy <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign hreadyout = q.hrdy;
	assign hresp = q.hresp;
	assign hrdata = q.hrdata;
	assign pci_o = q.o;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence last_phase_s;
		q.m == pmti_pkg::M_DATA && q.o.frame_l && !q.o.irdy_l && !q.s2.trdy_l && q.s2.stop_l;
	endsequence
	sequence release_s;
		pci_o.irdy_l ##1 !pci_o.frame_oe && !pci_o.irdy_oe;
	endsequence

	// a parked start never raised req_l, so only the released level is owed there
	req_drop_a: assert property ($fell(pci_o.frame_l) |-> pci_o.req_l && ($past(!pci_o.req_l) || $past(q.m == pmti_pkg::M_PARK)))
		else $error("req_l not released with frame_l");
	frame_gnt_a: assert property ($fell(pci_o.frame_l) |-> $past(!q.s2.gnt_l))
		else $error("frame_l asserted without grant");
	grant_keep_a: assert property (q.m == pmti_pkg::M_ADDR |=> q.m == pmti_pkg::M_DATA && !pci_o.irdy_l)
		else $error("transaction dropped after address phase");
	byte_all_a: assert property (q.m == pmti_pkg::M_DATA && pci_o.frame_oe |-> pci_o.cbe_l == 4'h0)
		else $error("byte enables not all active");
	last_release_a: assert property (last_phase_s |=> release_s)
		else $error("bus not released after final phase");
	parity_delay_a: assert property (pci_o.ad_oe && pci_o.cbe_oe |=> pci_o.par_oe
		&& pci_o.par == ^{$past(pci_o.ad), $past(pci_o.cbe_l)})
		else $error("parity wrong or late");
	master_abort_a: assert property (q.m == pmti_pkg::M_DATA && !q.devseen && q.s2.devsel_l && q.dwait == 3'h5
		|=> q.rma && q.fbe_m && pci_o.frame_l ##2 !pci_o.frame_oe)
		else $error("master abort not taken");
	target_abort_a: assert property (q.m == pmti_pkg::M_DATA && !q.s2.stop_l && q.s2.devsel_l
		&& (q.devseen || q.dwait != 3'h5) |=> q.rta && q.fbe_t && pci_o.irdy_l)
		else $error("target abort not taken");
	stop_hold_a: assert property (q.t == pmti_pkg::T_STOP && !q.s2.frame_l |=> !pci_o.stop_l && pci_o.trdy_l)
		else $error("stop_l released early");
	serr_pulse_a: assert property ($fell(pci_o.serr_l) |=> pci_o.serr_l && !pci_o.serr_oe)
		else $error("serr_l pulse not one cycle");
endmodule
`default_nettype wire

// >>> hdl/pmti_params.svh
// constants for the bus master/target interface block
`ifndef PMTI_PARAMS_SVH
`define PMTI_PARAMS_SVH
`define PMTI_OFS_MADDR 8'h00
`define PMTI_OFS_MCTRL 8'h04
`define PMTI_OFS_CONFIG_COMMAND_STATUS_REG 8'h08
`define PMTI_OFS_CSTAT 8'h0C
`define PMTI_BUF_SEL 2'h1
`define PMTI_CTRL_GO 0
`define PMTI_CTRL_WR 1
`define PMTI_CTRL_LEN_LSB 8
`define PMTI_CTRL_LAT_LSB 16
`define PMTI_CONFIG_COMMAND_STATUS_REG_DPR 24
`define PMTI_CONFIG_COMMAND_STATUS_REG_RTA 28
`define PMTI_CONFIG_COMMAND_STATUS_REG_RMA 29
`define PMTI_CSTAT_BUSY 0
`define PMTI_CSTAT_FBE_M 13
`define PMTI_CSTAT_FBE_T 15
`define PMTI_DEVSEL_WAIT 3'h5
`define PMTI_BACK_DISC 5'h01
`define PMTI_BACK_RETRY 5'h02
`define PMTI_TO_EXTRA 5'h02
`define PMTI_CMD_IORD 4'h2
`define PMTI_CMD_IOWR 4'h3
`define PMTI_CMD_MRD 4'h6
`define PMTI_CMD_MWR 4'h7
`define PMTI_CMD_MRM 4'hC
`define PMTI_CMD_MRL 4'hE
`define PMTI_CMD_MWI 4'hF
`define PMTI_CMD_CFG_HI 3'h5
`define PMTI_BE_ALL 4'h0
`define PMTI_CFG_ID_IDX 6'h00
`define PMTI_CFG_CSR_IDX 6'h01
`define PMTI_CFG_BAR_IDX 6'h04
`endif

// >>> hdl/pmti_pkg.sv
// types for the bus master/target interface block
package pmti_pkg;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_PARK = 3'b001,
		M_REQ = 3'b010,
		M_ADDR = 3'b011,
		M_DATA = 3'b100,
		M_FIN = 3'b101,
		M_END = 3'b110
	} pmti_mst_t;
	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_CLAIM = 3'b001,
		T_DATA = 3'b010,
		T_STOP = 3'b011,
		T_TURN = 3'b100
	} pmti_tgt_t;
	typedef struct packed {
		logic frame_l;
		logic irdy_l;
		logic trdy_l;
		logic stop_l;
		logic devsel_l;
		logic idsel;
		logic gnt_l;
		logic perr_l;
		logic par;
		logic [3:0] cbe_l;
		logic [31:0] ad;
	} pmti_pci_in_t;
	typedef struct packed {
		logic req_l;
		logic frame_l;
		logic frame_oe;
		logic irdy_l;
		logic irdy_oe;
		logic trdy_l;
		logic trdy_oe;
		logic devsel_l;
		logic devsel_oe;
		logic stop_l;
		logic stop_oe;
		logic [31:0] ad;
		logic ad_oe;
		logic [3:0] cbe_l;
		logic cbe_oe;
		logic par;
		logic par_oe;
		logic perr_l;
		logic perr_oe;
		logic serr_l;
		logic serr_oe;
	} pmti_pci_out_t;
	typedef struct packed {
		pmti_pci_in_t s1;
		pmti_pci_in_t s2;
		pmti_pci_in_t s3;
		pmti_pci_out_t o;
		pmti_mst_t m;
		pmti_tgt_t t;
		logic hrdy;
		logic hresp;
		logic ahb_ap;
		logic ahb_wr;
		logic [7:0] ahb_ofs;
		logic [31:0] hrdata;
		logic [31:0] maddr;
		logic mwr;
		logic [4:0] mlen;
		logic [7:0] lat;
		logic [7:0] latcnt;
		logic busy;
		logic [4:0] idx;
		logic [4:0] tlim;
		logic [2:0] dwait;
		logic devseen;
		logic [15:0] cmdreg;
		logic dpr;
		logic rta;
		logic rma;
		logic fbe_m;
		logic fbe_t;
		logic [5:0] tidx;
		logic [3:0] tcmd;
		logic tcfg;
		logic pchk;
		logic pdata;
		logic pmst;
		logic pexp;
		logic [15:0][31:0] dbuf;
		logic [63:0][31:0] cfg;
	} pmti_state_t;
endpackage

// >>> verif/pmti_bus_model.sv
// bus partner: arbiter, memory target, config host pins and wire resolution
`timescale 1ns/1ps
`default_nettype none
module pmti_bus_model (
	input wire logic sys_clk, // bus clock
	input wire logic rst, // async reset, high
	input wire pmti_pkg::pmti_pci_out_t co, // core pin drive
	input wire logic [2:0] mode, // 0 ok, 1 no claim, 2 abort, 3 disconnect, 4 retry
	input wire logic h_oe, // host drives frame, irdy, cbe
	input wire logic h_ad_oe, // host drives ad
	input wire logic h_frame_l, // host frame
	input wire logic h_irdy_l, // host ready
	input wire logic h_idsel, // config select
	input wire logic [3:0] h_cbe_l, // host command or enables
	input wire logic [31:0] h_ad, // host address or data
	output var pmti_pkg::pmti_pci_in_t pi // resolved pin levels
);
	logic [31:0] mem [0:255];
	logic [31:0] lad;
	logic [3:0] lcbe;
	logic [7:0] wa;
	logic [2:0] tm, lm, em;
	logic [1:0] st, gap;
	logic gnt_l, dv_l, tr_l, st_l, t_oe, a_oe, p, p_oe, rd;
	int nfr;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 32'hB000_0000 | 32'(i);
		end
	end
	// a new mode serves one transaction, later ones are answered normally
	assign em = (mode == lm) ? 3'h0 : mode;
	always_comb begin
		pi.frame_l = co.frame_oe ? co.frame_l : (h_oe ? h_frame_l : 1'h1);
		pi.irdy_l = co.irdy_oe ? co.irdy_l : (h_oe ? h_irdy_l : 1'h1);
		pi.trdy_l = co.trdy_oe ? co.trdy_l : (t_oe ? tr_l : 1'h1);
		pi.stop_l = co.stop_oe ? co.stop_l : (t_oe ? st_l : 1'h1);
		pi.devsel_l = co.devsel_oe ? co.devsel_l : (t_oe ? dv_l : 1'h1);
		pi.idsel = h_idsel;
		pi.gnt_l = gnt_l;
		pi.perr_l = co.perr_oe ? co.perr_l : 1'h1;
		pi.par = co.par_oe ? co.par : (p_oe ? p : ~p);
		// released lines show the inverse of their last level
		pi.cbe_l = co.cbe_oe ? co.cbe_l : (h_oe ? h_cbe_l : ~lcbe);
		pi.ad = co.ad_oe ? co.ad : (h_ad_oe ? h_ad : (a_oe ? mem[wa] : ~lad));
	end
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gnt_l <= 1'h1;
			dv_l <= 1'h1;
			tr_l <= 1'h1;
			st_l <= 1'h1;
			t_oe <= 1'h0;
			a_oe <= 1'h0;
			p_oe <= 1'h0;
			st <= 2'h0;
			lm <= 3'h0;
			nfr <= 0;
			lad <= 32'h0;
			lcbe <= 4'hF;
		end else begin
			gnt_l <= co.req_l;
			lad <= pi.ad;
			lcbe <= pi.cbe_l;
			p <= ^{pi.ad, pi.cbe_l};
			p_oe <= a_oe | h_ad_oe;
			gap <= gap + 2'h1;
			case (st)
			2'h0: if (!pi.frame_l && co.frame_oe) begin
				st <= 2'h1;
				tm <= em;
				lm <= mode;
				rd <= ~pi.cbe_l[0];
				a_oe <= ~pi.cbe_l[0] && em == 3'h0;
				wa <= pi.ad[9:2];
				nfr <= nfr + 1;
				gap <= 2'h0;
				t_oe <= em != 3'h1;
				dv_l <= em == 3'h2;
				st_l <= em < 3'h2;
				tr_l <= em != 3'h3;
			end
			2'h1: begin
				if (tm == 3'h0) tr_l <= gap != 2'h2;
				if (!pi.irdy_l && !pi.trdy_l) begin
					if (!rd) mem[wa] <= pi.ad;
					wa <= wa + 8'h1;
					if (tm == 3'h3) tr_l <= 1'h1;
				end
				if (pi.frame_l && (pi.irdy_l || !st_l || !pi.trdy_l)) begin
					st <= 2'h2;
					dv_l <= 1'h1;
					tr_l <= 1'h1;
					st_l <= 1'h1;
					a_oe <= 1'h0;
				end
			end
			default: begin
				t_oe <= 1'h0;
				st <= 2'h0;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench: register bus master, config host and bus partner
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [31:0] ID_VAL = 32'h1357_2468; // arbitrary identity value
	logic sys_clk, rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r, h_ad;
	logic [1:0] htrans;
	logic [2:0] hsize, mode;
	logic h_oe, h_ad_oe, h_frame_l, h_irdy_l, h_idsel;
	logic [3:0] h_cbe_l;
	logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h40};
	logic [2:0] tmode [2] = '{3'h3, 3'h4};
	logic [2:0] amode [2] = '{3'h2, 3'h1};
	logic [31:0] cfb [2] = '{32'h1000_0000, 32'h2000_0000};
	logic [31:0] csb [2] = '{32'h0000_8000, 32'h0000_2000};
	pmti_pkg::pmti_pci_in_t pi;
	pmti_pkg::pmti_pci_out_t po;
	int mismatches, comparisons, n0;
	pmti_core #(.ID_WORD(ID_VAL)) dut_u (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pci_i(pi), .pci_o(po));
	pmti_bus_model pm_u (.sys_clk(sys_clk), .rst(rst), .co(po), .mode(mode), .h_oe(h_oe), .h_ad_oe(h_ad_oe),
		.h_frame_l(h_frame_l), .h_irdy_l(h_irdy_l), .h_idsel(h_idsel), .h_cbe_l(h_cbe_l), .h_ad(h_ad), .pi(pi));
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'h0, a, 32'h0);
		chk(r, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask
	// one config cycle as the host, single data phase
	task automatic cfg(input logic wr, input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
		h_oe <= 1'h1;
		h_ad_oe <= 1'h1;
		h_frame_l <= 1'h0;
		h_idsel <= 1'h1;
		h_ad <= {24'h0, idx, 2'h0};
		h_cbe_l <= {3'h5, wr};
		@(posedge sys_clk);
		h_frame_l <= 1'h1;
		h_irdy_l <= 1'h0;
		h_idsel <= 1'h0;
		h_cbe_l <= be;
		h_ad <= wd;
		h_ad_oe <= wr;
		do @(posedge sys_clk); while (pi.trdy_l !== 1'h0);
		r = pi.ad;
		h_irdy_l <= 1'h1;
		h_ad_oe <= 1'h0;
		@(posedge sys_clk);
		h_oe <= 1'h0;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic mst(input logic wr, input logic [31:0] adr, input logic [4:0] len, input logic [7:0] lat);
		int n;
		n0 = pm_u.nfr;
		ahb(1'h1, 8'h00, adr);
		ahb(1'h1, 8'h04, {8'h0, lat, 3'h0, len, 6'h0, wr, 1'h1});
		n = 0;
		do begin
			ahb(1'h0, 8'h0C, 32'h0);
			n++;
		end while (r[0] !== 1'h0 && n < 400);
		// a transfer that never finishes counts as a mismatch
		if (r[0] !== 1'h0) begin
			mismatches++;
			$display("ERROR at %0t ns: got %h expected %h", $time, r, 32'h0);
		end
	endtask
	task automatic done(input string s);
		$display("test %s done: %0d checks, %0d errors", s, comparisons, mismatches);
	endtask
	task automatic wrap_up;
		$display("checks %0d, errors %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#1_000_000;
		mismatches++;
		wrap_up();
	end
	initial begin
		rst = 1'h1;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		mode = 3'h0;
		h_oe = 1'h0;
		h_ad_oe = 1'h0;
		h_frame_l = 1'h1;
		h_irdy_l = 1'h1;
		h_idsel = 1'h0;
		h_cbe_l = 4'hF;
		h_ad = 32'h0;
		mismatches = 0;
		comparisons = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'h0;
		ahb(1'h1, 8'h20, 32'hFFFF_FFFF);
		foreach (ofs[i]) rchk(ofs[i], 32'h0);
		done("reset values");
		ahb(1'h1, 8'h08, 32'h0000_0006);
		cfg(1'h0, 6'h00, 4'h0, 32'h0);
		chk(r, ID_VAL);
		cfg(1'h0, 6'h01, 4'h0, 32'h0);
		chk(r, 32'h0000_0006);
		cfg(1'h1, 6'h10, 4'h5, 32'hAABB_CCDD);
		cfg(1'h0, 6'h10, 4'h0, 32'h0);
		chk(r, 32'hAA00_CC00);
		done("config space");
		for (int i = 0; i < 6; i++) ahb(1'h1, 8'h40 + 8'(4 * i), 32'hC0DE_0000 + 32'(i));
		mst(1'h1, 32'h0000_0100, 5'h04, 8'hFF);
		for (int i = 0; i < 4; i++) chk(pm_u.mem[8'h40 + i], 32'hC0DE_0000 + 32'(i));
		rchk(8'h08, 32'h0000_0006);
		done("burst write");
		foreach (tmode[k]) begin
			mode <= tmode[k];
			mst(1'h1, 32'h0000_0300 + 32'(k * 64), 5'h02, 8'hFF);
			chk(pm_u.mem[8'hC0 + 16 * k], 32'hC0DE_0000);
			chk(pm_u.mem[8'hC1 + 16 * k], 32'hC0DE_0001);
			chk(32'(pm_u.nfr - n0 > 1), 32'h1);
		end
		done("disconnect and retry");
		mst(1'h1, 32'h0000_0380, 5'h06, 8'h01);
		for (int i = 0; i < 6; i++) chk(pm_u.mem[8'hE0 + i], 32'hC0DE_0000 + 32'(i));
		chk(32'(pm_u.nfr - n0 > 1), 32'h1);
		done("latency timeout");
		mst(1'h0, 32'h0000_0200, 5'h03, 8'hFF);
		for (int i = 0; i < 3; i++) rchk(8'h40 + 8'(4 * i), 32'hB000_0080 + 32'(i));
		rchk(8'h08, 32'h0000_0006);
		done("burst read");
		foreach (amode[k]) begin
			mode <= amode[k];
			mst(1'h1, 32'h0000_0000, 5'h02, 8'hFF);
			rchk(8'h08, cfb[k] | 32'h6);
			rchk(8'h0C, csb[k]);
			ahb(1'h1, 8'h08, cfb[k] | 32'h6);
			ahb(1'h1, 8'h0C, csb[k]);
			rchk(8'h08, 32'h0000_0006);
			rchk(8'h0C, 32'h0);
		end
		done("aborts");
		wrap_up();
	end
endmodule
`default_nettype wire
